// [core/crs_pkg.sv]
/*
  Constants, state encodings and state types shared by the CPU register set.
  Assumes a single 40 MHz CPU clock and an active-low asynchronous reset.
*/
package crs_pkg;

  localparam int CRS_WORD_W = 32;
  localparam int CRS_GPR_COUNT = 16;
  localparam int CRS_SEL_W = 4;
  localparam int CRS_VEC_NUM_W = 8;
  localparam int CRS_CTRL_SEL_W = 2;

  localparam logic [CRS_SEL_W-1:0] CRS_INDEX_GPR = 4'h0;
  localparam logic [CRS_SEL_W-1:0] CRS_STACK_GPR = 4'hF;

  // Status word layout
  localparam int CRS_STATUS_T_BIT = 0;
  localparam int CRS_STATUS_S_BIT = 1;
  localparam int CRS_STATUS_MASK_LO = 4;
  localparam int CRS_STATUS_MASK_HI = 7;
  localparam int CRS_STATUS_Q_BIT = 8;
  localparam int CRS_STATUS_M_BIT = 9;
  localparam logic [CRS_WORD_W-1:0] CRS_STATUS_IMPL_BITS = 32'h000003F3;
  localparam logic [CRS_WORD_W-1:0] CRS_STATUS_RESET = 32'h000000F0;

  localparam logic [CRS_WORD_W-1:0] CRS_VBASE_RESET = 32'h00000000;
  localparam logic [CRS_WORD_W-1:0] CRS_WORD_ZERO = 32'h00000000;

  // Vector table entries fetched after reset, relative to the vector base
  localparam logic [CRS_WORD_W-1:0] CRS_VEC_PC_OFFSET = 32'h00000000;
  localparam logic [CRS_WORD_W-1:0] CRS_VEC_SP_OFFSET = 32'h00000004;
  // One stack slot is one long word
  localparam logic [CRS_WORD_W-1:0] CRS_STACK_SLOT = 32'h00000004;
  localparam logic [1:0] CRS_VEC_SCALE_PAD = 2'h0;

  localparam logic [CRS_CTRL_SEL_W-1:0] CRS_CTRL_STATUS = 2'h0;
  localparam logic [CRS_CTRL_SEL_W-1:0] CRS_CTRL_GBASE = 2'h1;
  localparam logic [CRS_CTRL_SEL_W-1:0] CRS_CTRL_VBASE = 2'h2;

  typedef enum logic [2:0] {
    CRS_FETCH_PC = 3'h1,
    CRS_FETCH_SP = 3'h2,
    CRS_RUN = 3'h4
  } crs_phase_t;

  typedef struct packed {
    logic [CRS_GPR_COUNT-1:0][CRS_WORD_W-1:0] regs;
  } crs_gpr_state_t;

  typedef struct packed {
    crs_phase_t phase;
    logic vec_req;
    logic [CRS_WORD_W-1:0] vec_addr;
    logic ready;
    logic [CRS_WORD_W-1:0] status_word;
    logic [CRS_WORD_W-1:0] global_base;
    logic [CRS_WORD_W-1:0] vector_base;
    logic [CRS_WORD_W-1:0] mac_high;
    logic [CRS_WORD_W-1:0] mac_low;
    logic [CRS_WORD_W-1:0] return_link;
    logic [CRS_WORD_W-1:0] pc;
    logic [CRS_WORD_W-1:0] rd_a;
    logic [CRS_WORD_W-1:0] rd_b;
    logic [CRS_WORD_W-1:0] index_val;
    logic [CRS_WORD_W-1:0] stack_val;
    logic [CRS_WORD_W-1:0] push_addr;
    logic [CRS_WORD_W-1:0] gbase_ea;
    logic [CRS_WORD_W-1:0] exc_vec_addr;
  } crs_core_state_t;

endpackage

// [core/crs_gpr_if.sv]
/*
  Carrier between the register set core and its general register array.
  Assumes both ends run on the same CPU clock.
*/
`timescale 1ns/10ps
interface crs_gpr_if;
  import crs_pkg::*;
  logic wr_en;
  logic [CRS_SEL_W-1:0] wr_sel;
  logic [CRS_WORD_W-1:0] wr_data;
  logic [CRS_SEL_W-1:0] rd_a_sel;
  logic [CRS_SEL_W-1:0] rd_b_sel;
  logic [CRS_WORD_W-1:0] rd_a_data;
  logic [CRS_WORD_W-1:0] rd_b_data;
  logic [CRS_WORD_W-1:0] index_data;
  logic [CRS_WORD_W-1:0] stack_data;

  modport array (input wr_en, wr_sel, wr_data, rd_a_sel, rd_b_sel,
    output rd_a_data, rd_b_data, index_data, stack_data);
  modport core (output wr_en, wr_sel, wr_data, rd_a_sel, rd_b_sel,
    input rd_a_data, rd_b_data, index_data, stack_data);
endinterface

// [core/crs_gpr_file.sv]
/*
  General register array: sixteen long words, one write and two read ports.
  Assumes the core arbitrates the write port; reads are combinational.
*/
`timescale 1ns/10ps
module crs_gpr_file
  import crs_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  crs_gpr_if.array gif
);

  crs_gpr_state_t state;
  crs_gpr_state_t next_state;

  always_comb begin
    next_state = state;
    if (gif.wr_en) begin
      next_state.regs[gif.wr_sel] = gif.wr_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Two independent read ports alongside the write port
  assign gif.rd_a_data = state.regs[gif.rd_a_sel];
  assign gif.rd_b_data = state.regs[gif.rd_b_sel];
  assign gif.index_data = state.regs[CRS_INDEX_GPR];
  assign gif.stack_data = state.regs[CRS_STACK_GPR];

endmodule

// [core/crs_register_set.sv]
/*
  Architectural register set of the CPU core: general registers, control
  registers, system registers and the reset-time vector fetch.
  Assumes the pipeline and exception sequencer drive the write and select
  ports synchronously to CLK, and that the memory system answers vector
  reads with a one-cycle VEC_ACK carrying VEC_RDATA.
*/
`timescale 1ns/10ps
module crs_register_set
  import crs_pkg::*;
#(
  parameter logic [CRS_WORD_W-1:0] VEC_PC_OFFSET = CRS_VEC_PC_OFFSET,
  parameter logic [CRS_WORD_W-1:0] VEC_SP_OFFSET = CRS_VEC_SP_OFFSET
)
(
  input wire logic CLK,
  input wire logic NRST,
  // General register write port
  input wire logic GPR_WE,
  input wire logic [CRS_SEL_W-1:0] GPR_WSEL,
  input wire logic [CRS_WORD_W-1:0] GPR_WDATA,
  // General register read ports
  input wire logic [CRS_SEL_W-1:0] GPR_RSEL_A,
  input wire logic [CRS_SEL_W-1:0] GPR_RSEL_B,
  output logic [CRS_WORD_W-1:0] GPR_RDATA_A,
  output logic [CRS_WORD_W-1:0] GPR_RDATA_B,
  output logic [CRS_WORD_W-1:0] INDEX_DATA,
  output logic [CRS_WORD_W-1:0] STACK_PTR,
  output logic [CRS_WORD_W-1:0] STACK_PUSH_ADDR,
  // Control registers
  input wire logic CTRL_WE,
  input wire logic [CRS_CTRL_SEL_W-1:0] CTRL_SEL,
  input wire logic [CRS_WORD_W-1:0] CTRL_WDATA,
  output logic [CRS_WORD_W-1:0] STATUS_WORD,
  output logic [CRS_WORD_W-1:0] GLOBAL_BASE,
  output logic [CRS_WORD_W-1:0] VECTOR_BASE,
  input wire logic [CRS_WORD_W-1:0] GBASE_DISP,
  output logic [CRS_WORD_W-1:0] GBASE_EA,
  input wire logic [CRS_VEC_NUM_W-1:0] EXC_VEC_NUM,
  output logic [CRS_WORD_W-1:0] EXC_VEC_ADDR,
  // System registers
  input wire logic MAC_WE,
  input wire logic [CRS_WORD_W-1:0] MAC_HIGH_WDATA,
  input wire logic [CRS_WORD_W-1:0] MAC_LOW_WDATA,
  output logic [CRS_WORD_W-1:0] MAC_HIGH,
  output logic [CRS_WORD_W-1:0] MAC_LOW,
  input wire logic CALL_EN,
  input wire logic [CRS_WORD_W-1:0] CALL_RET_ADDR,
  input wire logic LINK_WE,
  input wire logic [CRS_WORD_W-1:0] LINK_WDATA,
  output logic [CRS_WORD_W-1:0] RETURN_LINK,
  input wire logic PC_WE,
  input wire logic [CRS_WORD_W-1:0] PC_WDATA,
  output logic [CRS_WORD_W-1:0] PROGRAM_COUNTER,
  // Reset-time vector table read
  output logic VEC_REQ,
  output logic [CRS_WORD_W-1:0] VEC_ADDR,
  input wire logic VEC_ACK,
  input wire logic [CRS_WORD_W-1:0] VEC_RDATA,
  output logic READY
);

  crs_core_state_t state;
  crs_core_state_t next_state;

  crs_gpr_if gif ();

  crs_gpr_file u_gpr_file (
    .clk(CLK),
    .nrst(NRST),
    .gif(gif)
  );

  logic init_sp_load;
  logic gpr_wr_en;
  logic [CRS_SEL_W-1:0] gpr_wr_sel;
  logic [CRS_WORD_W-1:0] gpr_wr_data;

  // Value a general register will hold after this edge
  function automatic logic [CRS_WORD_W-1:0] gpr_fwd(
    input logic [CRS_SEL_W-1:0] sel,
    input logic [CRS_WORD_W-1:0] cur,
    input logic we,
    input logic [CRS_SEL_W-1:0] wsel,
    input logic [CRS_WORD_W-1:0] wdata
  );
    logic [CRS_WORD_W-1:0] val;
    val = cur;
    if (we && (wsel == sel)) begin
      val = wdata;
    end
    return val;
  endfunction

  // Only implemented status bits can change; reserved bits stay zero
  function automatic logic [CRS_WORD_W-1:0] status_clean(
    input logic [CRS_WORD_W-1:0] value
  );
    return value & CRS_STATUS_IMPL_BITS;
  endfunction

  // Stack pointer comes from the vector table before the pipeline runs
  always_comb begin
    init_sp_load = (state.phase == CRS_FETCH_SP) && VEC_ACK;
    if (init_sp_load) begin
      gpr_wr_en = 1'b1;
      gpr_wr_sel = CRS_STACK_GPR;
      gpr_wr_data = VEC_RDATA;
    end else begin
      gpr_wr_en = GPR_WE && state.ready;
      gpr_wr_sel = GPR_WSEL;
      gpr_wr_data = GPR_WDATA;
    end
  end

  assign gif.wr_en = gpr_wr_en;
  assign gif.wr_sel = gpr_wr_sel;
  assign gif.wr_data = gpr_wr_data;
  assign gif.rd_a_sel = GPR_RSEL_A;
  assign gif.rd_b_sel = GPR_RSEL_B;

  always_comb begin
    logic [CRS_WORD_W-1:0] sp_next;
    logic [CRS_WORD_W-1:0] vbase_next;
    logic [CRS_WORD_W-1:0] gbase_next;
    sp_next = CRS_WORD_ZERO;
    vbase_next = CRS_WORD_ZERO;
    gbase_next = CRS_WORD_ZERO;
    next_state = state;

    case (state.phase)
      CRS_FETCH_PC: begin
        next_state.vec_req = 1'b1;
        if (VEC_ACK) begin
          next_state.pc = VEC_RDATA;
          next_state.vec_addr = state.vector_base + VEC_SP_OFFSET;
          next_state.phase = CRS_FETCH_SP;
        end
      end
      CRS_FETCH_SP: begin
        if (VEC_ACK) begin
          next_state.vec_req = 1'b0;
          next_state.ready = 1'b1;
          next_state.phase = CRS_RUN;
        end
      end
      CRS_RUN: begin
        next_state.vec_req = 1'b0;
        next_state.ready = 1'b1;
        if (CTRL_WE) begin
          case (CTRL_SEL)
            CRS_CTRL_STATUS: begin
              next_state.status_word = status_clean(CTRL_WDATA);
            end
            CRS_CTRL_GBASE: begin
              next_state.global_base = CTRL_WDATA;
            end
            CRS_CTRL_VBASE: begin
              next_state.vector_base = CTRL_WDATA;
            end
            default: begin
              next_state.status_word = state.status_word;
            end
          endcase
        end
        if (MAC_WE) begin
          next_state.mac_high = MAC_HIGH_WDATA;
          next_state.mac_low = MAC_LOW_WDATA;
        end
        // A call takes precedence over a plain move into the link
        if (CALL_EN) begin
          next_state.return_link = CALL_RET_ADDR;
        end else if (LINK_WE) begin
          next_state.return_link = LINK_WDATA;
        end
        if (PC_WE) begin
          next_state.pc = PC_WDATA;
        end
      end
      default: begin
        next_state.phase = CRS_FETCH_PC;
        next_state.vec_req = 1'b1;
        next_state.vec_addr = state.vector_base + VEC_PC_OFFSET;
        next_state.ready = 1'b0;
      end
    endcase

    // Registered read ports see a same-cycle write
    next_state.rd_a = gpr_fwd(GPR_RSEL_A, gif.rd_a_data, gpr_wr_en, gpr_wr_sel,
      gpr_wr_data);
    next_state.rd_b = gpr_fwd(GPR_RSEL_B, gif.rd_b_data, gpr_wr_en, gpr_wr_sel,
      gpr_wr_data);
    next_state.index_val = gpr_fwd(CRS_INDEX_GPR, gif.index_data, gpr_wr_en, gpr_wr_sel,
      gpr_wr_data);
    sp_next = gpr_fwd(CRS_STACK_GPR, gif.stack_data, gpr_wr_en, gpr_wr_sel, gpr_wr_data);
    next_state.stack_val = sp_next;
    next_state.push_addr = sp_next - CRS_STACK_SLOT;

    vbase_next = next_state.vector_base;
    gbase_next = next_state.global_base;
    next_state.gbase_ea = gbase_next + GBASE_DISP;
    next_state.exc_vec_addr = vbase_next + {{(CRS_WORD_W-CRS_VEC_NUM_W-
      $bits(CRS_VEC_SCALE_PAD)){1'b0}}, EXC_VEC_NUM, CRS_VEC_SCALE_PAD};
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state.phase <= CRS_FETCH_PC;
      state.vec_req <= 1'b1;
      state.vec_addr <= CRS_VBASE_RESET + VEC_PC_OFFSET;
      state.ready <= 1'b0;
      state.status_word <= CRS_STATUS_RESET;
      state.global_base <= CRS_WORD_ZERO;
      state.vector_base <= CRS_VBASE_RESET;
      state.mac_high <= CRS_WORD_ZERO;
      state.mac_low <= CRS_WORD_ZERO;
      state.return_link <= CRS_WORD_ZERO;
      state.pc <= CRS_WORD_ZERO;
      state.rd_a <= CRS_WORD_ZERO;
      state.rd_b <= CRS_WORD_ZERO;
      state.index_val <= CRS_WORD_ZERO;
      state.stack_val <= CRS_WORD_ZERO;
      state.push_addr <= CRS_WORD_ZERO;
      state.gbase_ea <= CRS_WORD_ZERO;
      state.exc_vec_addr <= CRS_WORD_ZERO;
    end else begin
      state <= next_state;
    end
  end

  assign GPR_RDATA_A = state.rd_a;
  assign GPR_RDATA_B = state.rd_b;
  assign INDEX_DATA = state.index_val;
  assign STACK_PTR = state.stack_val;
  assign STACK_PUSH_ADDR = state.push_addr;
  assign STATUS_WORD = state.status_word;
  assign GLOBAL_BASE = state.global_base;
  assign VECTOR_BASE = state.vector_base;
  assign GBASE_EA = state.gbase_ea;
  assign EXC_VEC_ADDR = state.exc_vec_addr;
  assign MAC_HIGH = state.mac_high;
  assign MAC_LOW = state.mac_low;
  assign RETURN_LINK = state.return_link;
  assign PROGRAM_COUNTER = state.pc;
  assign VEC_REQ = state.vec_req;
  assign VEC_ADDR = state.vec_addr;
  assign READY = state.ready;

endmodule

// [tb/crs_register_set_props.sv]
/*
  Concurrent checks on the ports of the CPU register set.
  Assumes it is bound to crs_register_set and shares its single clock and reset.
*/
`timescale 1ns/10ps
module crs_register_set_props
  import crs_pkg::*;
#(
  parameter logic [CRS_WORD_W-1:0] VEC_PC_OFFSET = CRS_VEC_PC_OFFSET,
  parameter logic [CRS_WORD_W-1:0] VEC_SP_OFFSET = CRS_VEC_SP_OFFSET
)
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic GPR_WE,
  input wire logic [CRS_SEL_W-1:0] GPR_WSEL,
  input wire logic [CRS_WORD_W-1:0] GPR_WDATA,
  input wire logic [CRS_SEL_W-1:0] GPR_RSEL_A,
  input wire logic [CRS_WORD_W-1:0] GPR_RDATA_A,
  input wire logic [CRS_WORD_W-1:0] INDEX_DATA,
  input wire logic [CRS_WORD_W-1:0] STACK_PTR,
  input wire logic [CRS_WORD_W-1:0] STACK_PUSH_ADDR,
  input wire logic [CRS_WORD_W-1:0] STATUS_WORD,
  input wire logic [CRS_WORD_W-1:0] GLOBAL_BASE,
  input wire logic [CRS_WORD_W-1:0] VECTOR_BASE,
  input wire logic [CRS_WORD_W-1:0] GBASE_DISP,
  input wire logic [CRS_WORD_W-1:0] GBASE_EA,
  input wire logic [CRS_VEC_NUM_W-1:0] EXC_VEC_NUM,
  input wire logic [CRS_WORD_W-1:0] EXC_VEC_ADDR,
  input wire logic MAC_WE,
  input wire logic [CRS_WORD_W-1:0] MAC_HIGH_WDATA,
  input wire logic [CRS_WORD_W-1:0] MAC_LOW_WDATA,
  input wire logic [CRS_WORD_W-1:0] MAC_HIGH,
  input wire logic [CRS_WORD_W-1:0] MAC_LOW,
  input wire logic CALL_EN,
  input wire logic [CRS_WORD_W-1:0] CALL_RET_ADDR,
  input wire logic [CRS_WORD_W-1:0] RETURN_LINK,
  input wire logic PC_WE,
  input wire logic [CRS_WORD_W-1:0] PC_WDATA,
  input wire logic [CRS_WORD_W-1:0] PROGRAM_COUNTER,
  input wire logic VEC_REQ,
  input wire logic [CRS_WORD_W-1:0] VEC_ADDR,
  input wire logic VEC_ACK,
  input wire logic [CRS_WORD_W-1:0] VEC_RDATA,
  input wire logic READY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_pc_ack;
    !READY && VEC_REQ && VEC_ACK && VEC_ADDR == VEC_PC_OFFSET;
  endsequence
  sequence s_sp_ack;
    !READY && VEC_REQ && VEC_ACK && VEC_ADDR == VEC_SP_OFFSET;
  endsequence
  a_gpr_wr_rd: assert property (READY && GPR_WE && GPR_RSEL_A == GPR_WSEL
    |=> GPR_RDATA_A == $past(GPR_WDATA)) else $error("read port missed a write");
  a_index_track: assert property (READY && GPR_WE && GPR_WSEL == CRS_INDEX_GPR
    |=> INDEX_DATA == $past(GPR_WDATA)) else $error("index value wrong");
  a_push_addr: assert property (READY |-> STACK_PUSH_ADDR == STACK_PTR - CRS_STACK_SLOT)
    else $error("push address wrong");
  a_gbase_ea: assert property (READY |=> GBASE_EA == GLOBAL_BASE + $past(GBASE_DISP))
    else $error("global base address wrong");
  a_exc_vec: assert property (READY
    |=> EXC_VEC_ADDR == VECTOR_BASE + {22'h0, $past(EXC_VEC_NUM), 2'h0})
    else $error("vector address wrong");
  a_mac_pair: assert property (READY && MAC_WE |=> MAC_HIGH == $past(MAC_HIGH_WDATA)
    && MAC_LOW == $past(MAC_LOW_WDATA)) else $error("mac pair wrong");
  a_call_link: assert property (READY && CALL_EN
    |=> RETURN_LINK == $past(CALL_RET_ADDR)) else $error("return link wrong");
  a_pc_write: assert property (READY && PC_WE |=> PROGRAM_COUNTER == $past(PC_WDATA))
    else $error("program counter write lost");
  a_status_init: assert property (!READY |-> STATUS_WORD == CRS_STATUS_RESET)
    else $error("status word not at reset value");
  a_pc_load: assert property (s_pc_ack |=> PROGRAM_COUNTER == $past(VEC_RDATA)
    && VEC_REQ && VEC_ADDR == VEC_SP_OFFSET) else $error("start address load wrong");
  a_sp_load: assert property (s_sp_ack |=> READY && !VEC_REQ
    && STACK_PTR == $past(VEC_RDATA)) else $error("stack pointer load wrong");
endmodule

bind crs_register_set crs_register_set_props #(.VEC_PC_OFFSET(VEC_PC_OFFSET),
  .VEC_SP_OFFSET(VEC_SP_OFFSET)) u_props (.CLK(CLK), .NRST(NRST), .GPR_WE(GPR_WE),
  .GPR_WSEL(GPR_WSEL), .GPR_WDATA(GPR_WDATA), .GPR_RSEL_A(GPR_RSEL_A),
  .GPR_RDATA_A(GPR_RDATA_A), .INDEX_DATA(INDEX_DATA), .STACK_PTR(STACK_PTR),
  .STACK_PUSH_ADDR(STACK_PUSH_ADDR), .STATUS_WORD(STATUS_WORD), .GLOBAL_BASE(GLOBAL_BASE),
  .VECTOR_BASE(VECTOR_BASE), .GBASE_DISP(GBASE_DISP), .GBASE_EA(GBASE_EA),
  .EXC_VEC_NUM(EXC_VEC_NUM),
  .EXC_VEC_ADDR(EXC_VEC_ADDR), .MAC_WE(MAC_WE), .MAC_HIGH_WDATA(MAC_HIGH_WDATA),
  .MAC_LOW_WDATA(MAC_LOW_WDATA), .MAC_HIGH(MAC_HIGH), .MAC_LOW(MAC_LOW), .CALL_EN(CALL_EN),
  .CALL_RET_ADDR(CALL_RET_ADDR), .RETURN_LINK(RETURN_LINK), .PC_WE(PC_WE),
  .PC_WDATA(PC_WDATA), .PROGRAM_COUNTER(PROGRAM_COUNTER), .VEC_REQ(VEC_REQ),
  .VEC_ADDR(VEC_ADDR), .VEC_ACK(VEC_ACK), .VEC_RDATA(VEC_RDATA), .READY(READY));

// [tb/crs_vec_mem.sv]
/*
  Vector table memory model answering the reset-time vector reads.
  Assumes requests stand until acknowledged; wait_cyc sets the answer delay.
*/
`timescale 1ns/10ps
module crs_vec_mem
  import crs_pkg::*;
#(
  parameter logic [CRS_WORD_W-1:0] PC_INIT = 32'h00001000,
  parameter logic [CRS_WORD_W-1:0] SP_INIT = 32'h0000FFF0
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] wait_cyc,
  input wire logic vec_req,
  input wire logic [CRS_WORD_W-1:0] vec_addr,
  output logic vec_ack,
  output logic [CRS_WORD_W-1:0] vec_rdata
);
  logic [3:0] cnt;
  logic [CRS_WORD_W-1:0] ack_addr;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      vec_ack <= 1'b0;
      ack_addr <= 32'h0;
      vec_rdata <= 32'h0;
    end else begin
      vec_ack <= 1'b0;
      // Outside an answer the data lines toggle, never holding a stale word
      vec_rdata <= ~vec_rdata;
      if (vec_req && !(vec_ack && vec_addr == ack_addr)) begin
        if (cnt >= wait_cyc) begin
          cnt <= 4'h0;
          vec_ack <= 1'b1;
          ack_addr <= vec_addr;
          vec_rdata <= (vec_addr == CRS_VEC_SP_OFFSET) ? SP_INIT : PC_INIT;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

// [tb/crs_register_set_tb.sv]
/*
  Self-checking testbench of the CPU register set.
  Assumes the vector memory model on the far side and a 40 MHz clock.
*/
`timescale 1ns/10ps
module crs_register_set_tb;
  import crs_pkg::*;
  localparam logic [31:0] PC_INIT = 32'h00001000;
  localparam logic [31:0] SP_INIT = 32'h0000FFF0;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic gpr_we = 1'b0, ctrl_we = 1'b0, mac_we = 1'b0, call_en = 1'b0, link_we = 1'b0;
  logic pc_we = 1'b0;
  logic [3:0] wsel = 4'h0, rsel_a = 4'h0, rsel_b = 4'h0, wait_cyc = 4'h3;
  logic [1:0] ctrl_sel = 2'h0;
  logic [7:0] vec_num = 8'h00;
  logic [31:0] gpr_wdata = 32'h0, ctrl_wdata = 32'h0, gbase_disp = 32'h0, mac_high_w = 32'h0;
  logic [31:0] mac_low_w = 32'h0, ret_addr = 32'h0, link_wdata = 32'h0, pc_wdata = 32'h0;
  logic [31:0] rd_a, rd_b, index_data, stack_ptr, push_addr, status_word, global_base;
  logic [31:0] vector_base, gbase_ea, exc_vec_addr, mac_high, mac_low, return_link, pc;
  logic [31:0] vec_addr, vec_rdata;
  logic vec_req, vec_ack, ready;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  crs_register_set dut (.CLK(clk), .NRST(nrst), .GPR_WE(gpr_we), .GPR_WSEL(wsel),
    .GPR_WDATA(gpr_wdata), .GPR_RSEL_A(rsel_a), .GPR_RSEL_B(rsel_b), .GPR_RDATA_A(rd_a),
    .GPR_RDATA_B(rd_b), .INDEX_DATA(index_data), .STACK_PTR(stack_ptr),
    .STACK_PUSH_ADDR(push_addr), .CTRL_WE(ctrl_we), .CTRL_SEL(ctrl_sel),
    .CTRL_WDATA(ctrl_wdata), .STATUS_WORD(status_word), .GLOBAL_BASE(global_base),
    .VECTOR_BASE(vector_base), .GBASE_DISP(gbase_disp), .GBASE_EA(gbase_ea),
    .EXC_VEC_NUM(vec_num), .EXC_VEC_ADDR(exc_vec_addr), .MAC_WE(mac_we),
    .MAC_HIGH_WDATA(mac_high_w), .MAC_LOW_WDATA(mac_low_w), .MAC_HIGH(mac_high),
    .MAC_LOW(mac_low), .CALL_EN(call_en),
    .CALL_RET_ADDR(ret_addr), .LINK_WE(link_we), .LINK_WDATA(link_wdata),
    .RETURN_LINK(return_link), .PC_WE(pc_we), .PC_WDATA(pc_wdata), .PROGRAM_COUNTER(pc),
    .VEC_REQ(vec_req), .VEC_ADDR(vec_addr), .VEC_ACK(vec_ack), .VEC_RDATA(vec_rdata),
    .READY(ready));

  crs_vec_mem #(.PC_INIT(PC_INIT), .SP_INIT(SP_INIT)) u_mem (.clk(clk), .nrst(nrst),
    .wait_cyc(wait_cyc), .vec_req(vec_req), .vec_addr(vec_addr), .vec_ack(vec_ack),
    .vec_rdata(vec_rdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Writes attempted during the vector fetch must be ignored
  task automatic do_reset(input logic [3:0] w);
    int i;
    nrst = 1'b0;
    wait_cyc = w;
    ctrl_we = 1'b1;
    ctrl_sel = CRS_CTRL_GBASE;
    ctrl_wdata = 32'hA5A5A5A5;
    gpr_we = 1'b1;
    wsel = CRS_INDEX_GPR;
    gpr_wdata = 32'hA5A5A5A5;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check({31'h0, vec_req}, 32'h1);
    check(vec_addr, CRS_VEC_PC_OFFSET);
    for (i = 0; i < 40 && ready !== 1'b1; i++) @(negedge clk);
    ctrl_we = 1'b0;
    gpr_we = 1'b0;
    check({31'h0, ready}, 32'h1);
    check(global_base, 32'h0);
    check(index_data, 32'h0);
    check(pc, PC_INIT);
    check(stack_ptr, SP_INIT);
    check(push_addr, SP_INIT - 32'h4);
    check(status_word, CRS_STATUS_RESET);
    check(vector_base, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_gpr();
    int i;
    for (i = 0; i < 16; i++) begin
      gpr_we = 1'b1;
      wsel = i[3:0];
      gpr_wdata = 32'h11110000 + i;
      rsel_a = i[3:0];
      rsel_b = i[3:0] - 4'h1;
      @(negedge clk);
      check(rd_a, 32'h11110000 + i);
      if (i > 0) check(rd_b, 32'h11110000 + i - 1);
    end
    gpr_we = 1'b0;
    check(index_data, 32'h11110000);
    check(stack_ptr, 32'h1111000F);
    check(push_addr, 32'h1111000B);
    $display("general register test done");
  endtask

  task automatic ctrl_wr(input logic [1:0] s, input logic [31:0] d);
    ctrl_we = 1'b1;
    ctrl_sel = s;
    ctrl_wdata = d;
    @(negedge clk);
  endtask

  // Selector 3 must leave all three control registers alone
  task automatic t_ctrl();
    gbase_disp = 32'h00000123;
    vec_num = 8'hFF;
    ctrl_wr(CRS_CTRL_STATUS, 32'hFFFFFFFF);
    ctrl_wr(CRS_CTRL_GBASE, 32'h00400000);
    ctrl_wr(CRS_CTRL_VBASE, 32'h00008000);
    ctrl_wr(2'h3, 32'hDEADBEEF);
    ctrl_we = 1'b0;
    @(negedge clk);
    check(status_word, CRS_STATUS_IMPL_BITS);
    check(global_base, 32'h00400000);
    check(gbase_ea, 32'h00400123);
    check(vector_base, 32'h00008000);
    check(exc_vec_addr, 32'h000083FC);
    $display("control register test done");
  endtask

  // Call and link write in one cycle: the call's return address wins
  task automatic t_sys();
    mac_we = 1'b1;
    mac_high_w = 32'h12345678;
    mac_low_w = 32'h9ABCDEF0;
    call_en = 1'b1;
    ret_addr = 32'h00002002;
    link_we = 1'b1;
    link_wdata = 32'h00007777;
    pc_we = 1'b1;
    pc_wdata = 32'h00003000;
    @(negedge clk);
    mac_we = 1'b0;
    call_en = 1'b0;
    pc_we = 1'b0;
    link_wdata = 32'h00004444;
    check(mac_high, 32'h12345678);
    check(mac_low, 32'h9ABCDEF0);
    check(return_link, 32'h00002002);
    check(pc, 32'h00003000);
    @(negedge clk);
    link_we = 1'b0;
    check(return_link, 32'h00004444);
    check(pc, 32'h00003000);
    $display("system register test done");
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    do_reset(4'h3);
    t_gpr();
    t_ctrl();
    t_sys();
    do_reset(4'h0);
    end_of_test();
  end
endmodule
